// >>> design/dac_latch_ref_cfg.sv
// command decoder for latch-mode and reference settings of a quad dac
// Functional notes
// - latch-mode command: bit23 zero, bits21..19 = 110; bits 22, 18..12 ignored
// - latch bit 0 loads on load command; 1 passes code straight through
// - reference command: bit23 zero, bits21..19 = 111; bits 22, 18..3 ignored
// - reference selection is global, replacing all channels at once
// - mode 00 external; 01 2.500V, 10 2.048V, 11 4.096V internal
// - keep-alive zero: reference powers down when every channel is down
// - keep-alive one: reference stays on; deepest shutdown not entered
// - all four channels powered down is the standby state
// - power-up forces zero-scale outputs, then runs 200us setup
// - commands arriving before setup finishes are discarded
// - frame is command byte, data high byte, data low byte
`timescale 1ns/1ps
`default_nettype none
module dac_latch_ref_cfg
  import dac_cfg_pkg::*;
#(
  parameter int SETUP_COUNT = SETUP_CYCLES
) (
  input  wire logic                clk,            // 50 MHz clock
  input  wire logic                rst_b,          // sync reset, active low
  input  wire logic [FRAME_W-1:0]  frame,          // command, data high, data low
  input  wire logic                frame_valid,    // one-cycle strobe of a full frame
  input  wire logic                load_strobe,    // load command pulse, one strobe shared by all channels
  input  wire logic [CHAN_N-1:0]   load_chan,      // channels hit by the load
  input  wire logic [CHAN_N-1:0]   chan_pd,        // channel powered down flags
  output logic     [CHAN_N-1:0]    latch_mode,     // 1 = transparent latch
  output logic     [CHAN_N-1:0]    latch_aux,      // captured upper channel bits
  output logic     [CHAN_N-1:0]    latch_update,   // dac latch takes code this cycle
  output logic     [1:0]           ref_mode,       // reference source select
  output logic                     ref_keep_alive, // keep reference on in standby
  output logic                     ref_power_on,   // internal reference powered
  output logic                     deep_shutdown,  // lowest-current state allowed
  output logic                     standby,        // every channel powered down
  output logic                     force_zero,     // outputs held at zero scale
  output logic                     ready           // setup done, commands accepted
);

  //----------------------------------------
  // power-up setup timer
  //----------------------------------------
  localparam int CNT_W = $clog2(SETUP_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETUP_COUNT - 1);

  logic [CNT_W-1:0] setup_cnt_r;
  logic [CNT_W-1:0] setup_cnt_nxt;
  logic             ready_r;
  logic             ready_nxt;

  wire setup_end = !ready_r && (setup_cnt_r == CNT_LAST);
  assign setup_cnt_nxt = ready_r ? setup_cnt_r : setup_cnt_r + CNT_W'(1);
  assign ready_nxt     = ready_r | setup_end;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setup_cnt_r <= '0;
      ready_r     <= 1'b0;
    end else begin
      setup_cnt_r <= setup_cnt_nxt;
      ready_r     <= ready_nxt;
    end
  end

  //----------------------------------------
  // frame decode
  //----------------------------------------
  frame_s     frm;
  assign frm = frame;
  wire [2:0]  opcode    = frame[CMD_OP_HI:CMD_OP_LO];
  wire        rsv_ok    = !frame[CMD_RSV_BIT];
  wire        accept    = frame_valid && ready_r;
  wire        is_latch  = accept && rsv_ok && (opcode == OP_LATCH_MODE);
  wire        is_ref    = accept && rsv_ok && (opcode == OP_REFERENCE);
  wire [3:0]  latch_in  = frame[LATCH_LO_HI:LATCH_LO_LO];
  wire [3:0]  aux_in    = frame[LATCH_HI_HI:LATCH_HI_LO];
  ref_sel_s   ref_in;
  assign ref_in.keep_alive = frm.data_lo[REF_KEEP_BIT];
  assign ref_in.mode       = frm.data_lo[REF_MODE_HI:REF_MODE_LO];

  //----------------------------------------
  // configuration registers
  //----------------------------------------
  logic [3:0] latch_mode_select_r;
  logic [3:0] latch_aux_r;
  ref_sel_s   reference_select_r;
  logic [3:0] latch_mode_select_nxt;
  logic [3:0] latch_aux_nxt;
  ref_sel_s   reference_select_nxt;

  assign latch_mode_select_nxt = is_latch ? latch_in : latch_mode_select_r;
  assign latch_aux_nxt         = is_latch ? aux_in : latch_aux_r;
  assign reference_select_nxt  = is_ref ? ref_in : reference_select_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latch_mode_select_r <= LATCH_RESET;
      latch_aux_r         <= LATCH_RESET;
      reference_select_r  <= REF_RESET;
    end else begin
      latch_mode_select_r <= latch_mode_select_nxt;
      latch_aux_r         <= latch_aux_nxt;
      reference_select_r  <= reference_select_nxt;
    end
  end

  //----------------------------------------
  // derived controls and output flops
  //----------------------------------------
  wire        all_down   = &chan_pd;
  wire        ref_on_nxt = !(all_down && !reference_select_nxt.keep_alive);
  wire        deep_nxt   = all_down && !reference_select_nxt.keep_alive;
  wire [3:0]  upd_nxt    = latch_mode_select_nxt | (load_strobe ? load_chan : 4'h0);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latch_mode     <= LATCH_RESET;
      latch_aux      <= LATCH_RESET;
      latch_update   <= LATCH_RESET;
      ref_mode       <= REF_EXTERNAL;
      ref_keep_alive <= 1'b0;
      ref_power_on   <= 1'b1;
      deep_shutdown  <= 1'b0;
      standby        <= 1'b0;
      force_zero     <= 1'b1;
      ready          <= 1'b0;
    end else begin
      latch_mode     <= latch_mode_select_nxt;
      latch_aux      <= latch_aux_nxt;
      latch_update   <= upd_nxt;
      ref_mode       <= reference_select_nxt.mode;
      ref_keep_alive <= reference_select_nxt.keep_alive;
      ref_power_on   <= ref_on_nxt;
      deep_shutdown  <= deep_nxt;
      standby        <= all_down;
      force_zero     <= !ready_nxt;
      ready          <= ready_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> shared/dac_cfg_pkg.sv
// constants and carriers for the latch-mode and reference command decoder
package dac_cfg_pkg;
  localparam int          FRAME_W        = 24;
  localparam int          BYTE_W         = 8;
  localparam int          CHAN_N         = 4;
  localparam int          CMD_RSV_BIT    = 23;
  localparam int          CMD_OP_HI      = 21;
  localparam int          CMD_OP_LO      = 19;
  localparam logic [2:0]  OP_LATCH_MODE  = 3'h6;
  localparam logic [2:0]  OP_REFERENCE   = 3'h7;
  localparam int          LATCH_LO_HI    = 3;
  localparam int          LATCH_LO_LO    = 0;
  localparam int          LATCH_HI_HI    = 11;
  localparam int          LATCH_HI_LO    = 8;
  localparam int          REF_KEEP_BIT   = 2;
  localparam int          REF_MODE_HI    = 1;
  localparam int          REF_MODE_LO    = 0;
  localparam logic [3:0]  LATCH_RESET    = 4'h0;
  localparam logic [2:0]  REF_RESET      = 3'h0;
  localparam logic [1:0]  REF_EXTERNAL   = 2'h0;
  localparam logic [1:0]  REF_INT_2V500  = 2'h1;
  localparam logic [1:0]  REF_INT_2V048  = 2'h2;
  localparam logic [1:0]  REF_INT_4V096  = 2'h3;
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          SETUP_TIME_US  = 200;
  localparam int          SETUP_CYCLES   = (SETUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       keep_alive;
    logic [1:0] mode;
  } ref_sel_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data_hi;
    logic [7:0] data_lo;
  } frame_s;
endpackage

// >>> test/dac_cfg_monitor.sv
// protocol checker for the latch-mode and reference decoder
`timescale 1ns/1ps
`default_nettype none
module dac_cfg_monitor
  import dac_cfg_pkg::*;
#(parameter int SETUP_COUNT = 8) (
  input wire logic               clk,            // clock
  input wire logic               rst_b,          // sync reset
  input wire logic [FRAME_W-1:0] frame,          // command frame
  input wire logic               frame_valid,    // frame strobe
  input wire logic [CHAN_N-1:0]  chan_pd,        // channel down flags
  input wire logic [CHAN_N-1:0]  latch_mode,     // transparent bits
  input wire logic [CHAN_N-1:0]  latch_aux,      // upper bits
  input wire logic [CHAN_N-1:0]  latch_update,   // latch follows code
  input wire logic [1:0]         ref_mode,       // reference source
  input wire logic               ref_keep_alive, // keep reference on
  input wire logic               ref_power_on,   // reference powered
  input wire logic               deep_shutdown,  // lowest-current state
  input wire logic               standby,        // all channels down
  input wire logic               force_zero,     // zero-scale hold
  input wire logic               ready           // setup done
);
  logic [15:0] wait_r;
  always_ff @(posedge clk) wait_r <= (!rst_b || ready) ? 16'h0000 : wait_r + 16'h0001;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence take_latch; frame_valid && ready && !frame[23] && frame[21:19] == OP_LATCH_MODE; endsequence
  sequence take_ref; frame_valid && ready && !frame[23] && frame[21:19] == OP_REFERENCE; endsequence
  latch_set_a: assert property (take_latch |=> latch_mode == $past(frame[3:0]) && latch_aux == $past(frame[11:8]))
    else $error("latch setting wrong");
  ref_set_a: assert property (take_ref |=> {ref_keep_alive, ref_mode} == $past(frame[2:0]))
    else $error("reference setting wrong");
  cfg_hold_a: assert property ((!ready || !frame_valid) |=> $stable({latch_mode, latch_aux, ref_mode, ref_keep_alive}))
    else $error("setting changed without command");
  ref_power_a: assert property (ref_power_on == !(standby && !ref_keep_alive))
    else $error("reference power wrong");
  shut_deny_a: assert property (deep_shutdown == (standby && !ref_keep_alive))
    else $error("shutdown state wrong");
  standby_a: assert property ($past(rst_b) |-> standby == $past(&chan_pd))
    else $error("standby wrong");
  zero_scale_a: assert property (force_zero == !ready)
    else $error("zero-scale hold wrong");
  setup_len_a: assert property (!ready |-> wait_r < SETUP_COUNT)
    else $error("setup too long");
  setup_exact_a: assert property ($rose(ready) |-> wait_r == SETUP_COUNT)
    else $error("setup length wrong");
  transparent_a: assert property ((latch_update & latch_mode) == latch_mode)
    else $error("transparent latch not following");
endmodule
bind dac_latch_ref_cfg dac_cfg_monitor #(.SETUP_COUNT(SETUP_COUNT)) i_dac_cfg_monitor (.clk, .rst_b, .frame,
  .frame_valid, .chan_pd, .latch_mode, .latch_aux, .latch_update, .ref_mode, .ref_keep_alive, .ref_power_on,
  .deep_shutdown, .standby, .force_zero, .ready);
`default_nettype wire

// >>> test/dac_latch_and_reference_config_test.sv
// self-checking bench for the latch-mode and reference decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module dac_latch_and_reference_config_test
  import dac_cfg_pkg::*;
;
  logic clk = 0, rst_b = 0, load_strobe = 0, frame_valid, v_d = 0, ready, force_zero, keep, pwr, deep, stby, all_dn;
  logic [3:0] load_chan = 0, chan_pd = 0, lm, aux, upd, e_lm = 0, e_aux = 0;
  logic [2:0] e_ref = 0;
  logic [1:0] rm;
  logic [23:0] frame, f;
  logic [12:0] ev, exp_q[$];
  logic [31:0] r = 32'h0000_d887;
  int n_fail = 0, compares = 0;
  always #10 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; return x ^ (x << 5);
  endfunction
  i2c_host_model i_i2c_host_model (.clk, .frame, .frame_valid);
  dac_latch_ref_cfg #(.SETUP_COUNT(8)) i_dac_latch_ref_cfg (.clk, .rst_b, .frame, .frame_valid, .load_strobe,
    .load_chan, .chan_pd, .latch_mode(lm), .latch_aux(aux), .latch_update(upd), .ref_mode(rm),
    .ref_keep_alive(keep), .ref_power_on(pwr), .deep_shutdown(deep), .standby(stby), .force_zero, .ready);
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) v_d <= frame_valid;
  always @(negedge clk) if (v_d) begin
    ev = exp_q.pop_front();
    `CHK({lm, aux, keep, rm, stby, pwr}, ev)
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    #1 `CHK({ready, force_zero, lm, keep, rm}, 9'h080)
    exp_q.push_back(13'h0001);
    i_i2c_host_model.send(24'h30_000f);
    for (int k = 0; k < 50 && ready !== 1'b1; k++) @(posedge clk);
    for (int n = 0; n < 120; n++) begin
      r = xs(r);
      f = r[23:0];
      if (!r[27]) f[21:19] = r[25] ? OP_REFERENCE : OP_LATCH_MODE;
      f[23] = &r[29:28];
      if (!f[23] && f[21:19] == OP_LATCH_MODE) {e_aux, e_lm} = {f[11:8], f[3:0]};
      if (!f[23] && f[21:19] == OP_REFERENCE) e_ref = f[2:0];
      all_dn = r[30] | (&r[3:0]);
      chan_pd <= r[30] ? 4'hf : r[3:0];
      load_strobe <= r[31];
      load_chan <= r[9:6];
      exp_q.push_back({e_lm, e_aux, e_ref, all_dn, !(all_dn && !e_ref[2])});
      i_i2c_host_model.send(f);
    end
    repeat (3) @(posedge clk);
    if (exp_q.size() != 0) n_fail++;
    test_done;
  end
endmodule
`default_nettype wire

// >>> test/i2c_host_model.sv
// serial host that assembles three bytes into a command frame
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
  import dac_cfg_pkg::*;
(
  input  wire logic               clk,         // clock
  output logic     [FRAME_W-1:0]  frame,       // assembled frame
  output logic                    frame_valid  // one-cycle strobe
);
  logic [FRAME_W-1:0] sr_r;
  initial begin
    frame = '0;
    frame_valid = 1'b0;
    sr_r = '0;
  end
  task automatic send(input frame_s f);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sr_r <= {sr_r[15:0], f[23-8*i -: BYTE_W]};
    end
    @(posedge clk);
    frame <= sr_r;
    frame_valid <= 1'b1;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame <= ~sr_r;
  endtask
endmodule
`default_nettype wire
